// >>> design/fpga_config_handshake_control.v
// What this block does
// - test-port configuration wins; active-serial configuration is aborted.
// - configuration scheme comes from the two-bit scheme select value.
// - low configure request in user mode clears config, resets, floats user I/O.
// - rising configure request starts a new configuration; only way to reconfigure.
// - error status driven low at power-up, released within 5 us.
// - a configuration error pulls the error status line low.
// - error status pulled low outside during config or init gives error state.
// - after init, error status line levels and edges are ignored.
// - configuration-done held low before and during configuration.
// - configuration-done released once all data arrives without error.
// - once configuration-done reads high, initialise then enter user mode.
// - after init, a low configuration-done line has no effect.
`timescale 1ns/1ps
`include "cfg_handshake_regs.vh"
module fpga_config_handshake_control
#(
  parameter [31:0] POR_HOLD_CYCLES = `POR_HOLD_CYC,
  parameter [31:0] CFG_BITS = `CFG_BITS_DEFAULT
)
(
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // configuration pins
  input wire [1:0] schemeSelect,
  input wire configRequest_n,
  input wire chainEnable_n,
  // error status open-drain pin
  input wire errorStatusIn_n,
  output wire errorStatusOut_n,
  output wire errorStatusOe,
  // configuration-done open-drain pin
  input wire configCompleteIn,
  output wire configCompleteOut,
  output wire configCompleteOe,
  // configuration data from the loader
  input wire dataStrobe,
  input wire dataError,
  input wire testPortActive,
  input wire activeSerialActive,
  // user-mode results
  output reg userMode_r,
  output reg userIoFloat_r,
  output reg activeSerialEn_r,
  output reg [1:0] scheme_r,
  // register port
  input wire [3:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdData,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////
  localparam ST_POR = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_CONFIG = 3'h2;
  localparam ST_INIT = 3'h3;
  localparam ST_USER = 3'h4;
  localparam ST_ERROR = 3'h5;
  localparam ST_RESET = 3'h6;

  wire [3:0] pinsSync;
  wire [1:0] selSync;
  wire cfgReqSync;
  wire errLineSync;
  wire doneLineSync;
  wire ceSync;
  reg cfgReqPrev_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [31:0] count_r;
  reg [31:0] count_nxt;
  reg errDrive_r;
  reg doneDrive_r;
  reg [`IRQ_WIDTH-1:0] events;
  reg softReconfig_r;
  wire [`IRQ_WIDTH-1:0] irqStat;
  wire [`IRQ_WIDTH-1:0] irqMask;
  wire cfgReqRise;
  wire [1:0] odDrive;
  wire [1:0] odLevel;
  wire [1:0] odEnable;
  reg [1:0] schemeNext;
  genvar odIdx;

  ////////////////////////////////////////////////////////////////////////////
  // every pin passes two flops before any logic reads it
  pin_sync #(.WIDTH(5)) uPinSync
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn({errorStatusIn_n, configCompleteIn, chainEnable_n, configRequest_n}),
    .syncOut(pinsSync)
  );

  pin_sync #(.WIDTH(2)) uSelSync
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(schemeSelect),
    .syncOut(selSync)
  );

  assign errLineSync = pinsSync[3];
  assign doneLineSync = pinsSync[2];
  assign ceSync = pinsSync[1];
  assign cfgReqSync = pinsSync[0];
  // the sync resets low, so a false rise follows reset; the power-up hold outlasts it
  assign cfgReqRise = cfgReqSync & ~cfgReqPrev_r;

  ////////////////////////////////////////////////////////////////////////////
  // open-drain: only ever drive low; the wire is wired-and of all drivers
  // index 0 is the error status line, index 1 the configuration-done line
  assign odDrive = {doneDrive_r, errDrive_r};
  generate
    for (odIdx = 0; odIdx < 2; odIdx = odIdx + 1)
    begin : gOpenDrain
      // the value is a constant low; only the enable ever moves
      assign odLevel[odIdx] = 1'b0;
      assign odEnable[odIdx] = odDrive[odIdx];
    end
  endgenerate
  assign errorStatusOut_n = odLevel[0];
  assign errorStatusOe = odEnable[0];
  assign configCompleteOut = odLevel[1];
  assign configCompleteOe = odEnable[1];

  ////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    state_nxt = state_r;
    count_nxt = count_r;
    events = {`IRQ_WIDTH{1'b0}};
    case (state_r)
      ST_POR:
      begin
        // own drive released within the hold; 5 us at 200 MHz rounds down
        if (count_r >= POR_HOLD_CYCLES - 32'h0000_0001)
        begin
          state_nxt = ST_WAIT;
          count_nxt = 32'h0000_0000;
        end
        else
          count_nxt = count_r + 32'h0000_0001;
      end
      ST_WAIT:
      begin
        // a memory may keep the line low for long; simply wait for high
        if (errLineSync && cfgReqSync && !ceSync)
        begin
          state_nxt = ST_CONFIG;
          count_nxt = 32'h0000_0000;
        end
      end
      ST_CONFIG:
      begin
        if (!cfgReqSync)
          state_nxt = ST_RESET;
        else if (!errLineSync || dataError)
        begin
          state_nxt = ST_ERROR;
          events[`IRQ_ERR_BIT] = 1'b1;
        end
        // test port wins: active serial is dropped, and no data strobe is counted while both are active
        else if (testPortActive && activeSerialActive)
          events[`IRQ_ABORT_BIT] = 1'b1;
        else if (dataStrobe)
        begin
          if (count_r >= CFG_BITS - 32'h0000_0001)
            state_nxt = ST_INIT;
          count_nxt = count_r + 32'h0000_0001;
        end
      end
      ST_INIT:
      begin
        if (!cfgReqSync)
          state_nxt = ST_RESET;
        else if (!errLineSync)
        begin
          state_nxt = ST_ERROR;
          events[`IRQ_ERR_BIT] = 1'b1;
        end
        // another device may still hold the line; user mode waits for high
        else if (doneLineSync)
        begin
          state_nxt = ST_USER;
          events[`IRQ_DONE_BIT] = 1'b1;
        end
      end
      ST_USER:
      begin
        // error status and configuration-done lines are not looked at here
        if (!cfgReqSync || softReconfig_r)
          state_nxt = ST_RESET;
      end
      ST_ERROR:
      begin
        // held here with the line pulled low until the request goes low
        if (!cfgReqSync)
          state_nxt = ST_RESET;
      end
      ST_RESET:
      begin
        // only a low-then-high on the request restarts configuration
        if (cfgReqRise)
        begin
          state_nxt = ST_WAIT;
          events[`IRQ_RECFG_BIT] = 1'b1;
        end
      end
      default:
        state_nxt = ST_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // scheme in force next cycle: the pins are taken only as a configuration starts
  always @*
  begin
    schemeNext = scheme_r;
    if (state_r == ST_WAIT && state_nxt == ST_CONFIG)
      schemeNext = selSync;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_POR;
      count_r <= 32'h0000_0000;
      cfgReqPrev_r <= 1'b0;
      errDrive_r <= 1'b1;
      doneDrive_r <= 1'b1;
      userMode_r <= 1'b0;
      userIoFloat_r <= 1'b1;
      activeSerialEn_r <= 1'b0;
      scheme_r <= `SCHEME_AS;
    end
    else
    begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      cfgReqPrev_r <= cfgReqSync;
      // registered drives: the open-drain enables never glitch between states
      errDrive_r <= (state_nxt == ST_POR) || (state_nxt == ST_ERROR)
        || (state_nxt == ST_RESET);
      doneDrive_r <= (state_nxt != ST_INIT) && (state_nxt != ST_USER);
      userMode_r <= (state_nxt == ST_USER);
      userIoFloat_r <= (state_nxt != ST_USER);
      scheme_r <= schemeNext;
      // the new scheme, not the last one, decides; no stale first cycle
      activeSerialEn_r <= (state_nxt == ST_CONFIG) && (schemeNext == `SCHEME_AS)
        && !testPortActive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // soft reconfigure: one-cycle pulse from the control register
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      softReconfig_r <= 1'b0;
    else
      softReconfig_r <= regWr && (regAddr == `REG_CONTROL) && regWrData[0];
  end

  // status bits are write-one-to-clear; an event in the clearing cycle wins
  irq_regs uIrq
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .events(events),
    .statClr(regWr && (regAddr == `REG_IRQ_STAT)),
    .maskWr(regWr && (regAddr == `REG_IRQ_MASK)),
    .wrData(regWrData[`IRQ_WIDTH-1:0]),
    .stat_r(irqStat),
    .mask_r(irqMask),
    .irq(irq)
  );

  // read data stand one cycle only and are zero otherwise, so stale reads show
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdData <= 32'h0000_0000;
    else if (regRd)
    begin
      case (regAddr)
        `REG_STATUS: regRdData <= {24'h00_0000, scheme_r, userMode_r, 2'h0, state_r};
        `REG_IRQ_STAT: regRdData <= {28'h000_0000, irqStat};
        `REG_IRQ_MASK: regRdData <= {28'h000_0000, irqMask};
        default: regRdData <= 32'h0000_0000;
      endcase
    end
    else
      regRdData <= 32'h0000_0000;
  end
endmodule // fpga_config_handshake_control

// >>> design/cfg_handshake_regs.vh
`ifndef CFG_HANDSHAKE_REGS_VH
`define CFG_HANDSHAKE_REGS_VH

// scheme select encodings
`define SCHEME_AS 2'h0
`define SCHEME_PS 2'h1
`define SCHEME_RSV2 2'h2
`define SCHEME_RSV3 2'h3

// power-up hold of the error status line, in ns
`define POR_HOLD_NS 5000
`define CLK_PERIOD_NS 5
// longest time rounds down; 1000 cycles
`define POR_HOLD_CYC (`POR_HOLD_NS / `CLK_PERIOD_NS)

// configuration data length in bits
`define CFG_BITS_DEFAULT 32'h0000_0400

// interrupt register layout, indices
`define IRQ_DONE_BIT 0
`define IRQ_ERR_BIT 1
`define IRQ_ABORT_BIT 2
`define IRQ_RECFG_BIT 3
`define IRQ_WIDTH 4

// register offsets
`define REG_STATUS 4'h0
`define REG_IRQ_STAT 4'h4
`define REG_IRQ_MASK 4'h8
`define REG_CONTROL 4'hc

`endif

// >>> design/pin_sync.v
`timescale 1ns/1ps
module pin_sync
#(
  parameter WIDTH = 1
)
(
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // pins in, synchronised out
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_r;

  // metastable stage feeds only the second stage
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= pinIn;
      syncOut <= meta_r;
    end
  end
endmodule // pin_sync

// >>> design/irq_regs.v
`timescale 1ns/1ps
`include "cfg_handshake_regs.vh"
module irq_regs
(
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // events
  input wire [`IRQ_WIDTH-1:0] events,
  // software access
  input wire statClr,
  input wire maskWr,
  input wire [`IRQ_WIDTH-1:0] wrData,
  output reg [`IRQ_WIDTH-1:0] stat_r,
  output reg [`IRQ_WIDTH-1:0] mask_r,
  output wire irq
);
  reg [`IRQ_WIDTH-1:0] stat_nxt;

  // an event in the clearing cycle wins over the clear
  always @*
  begin
    stat_nxt = stat_r;
    if (statClr)
      stat_nxt = stat_nxt & ~wrData;
    stat_nxt = stat_nxt | events;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_r <= {`IRQ_WIDTH{1'b0}};
      mask_r <= {`IRQ_WIDTH{1'b0}};
    end
    else
    begin
      stat_r <= stat_nxt;
      if (maskWr)
        mask_r <= wrData;
    end
  end

  assign irq = |(stat_r & mask_r);
endmodule // irq_regs

// >>> tb/cfg_handshake_properties.sv
`timescale 1ns/1ps
module cfg_handshake_checker
(
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // pins
  input wire [1:0] schemeSelect,
  input wire configRequest_n,
  input wire testPortActive,
  input wire configCompleteIn,
  input wire regWr,
  // results
  input wire errorStatusOe,
  input wire configCompleteOe,
  input wire userMode_r,
  input wire userIoFloat_r,
  input wire activeSerialEn_r,
  input wire [1:0] scheme_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence porHold;
    $rose(rst_n) ##0 errorStatusOe [*8];
  endsequence
  sequence reqDrop;
    userMode_r ##0 $fell(configRequest_n);
  endsequence
  por_hold_a: assert property (porHold |-> ##[1:6] !errorStatusOe)
    else $error("error line not released in time");
  user_done_a: assert property (
    $rose(userMode_r) |-> configCompleteIn && !configCompleteOe)
    else $error("user mode without done line high");
  req_reset_a: assert property (reqDrop |-> ##[1:6] (userIoFloat_r && !userMode_r))
    else $error("request low did not reset");
  float_user_a: assert property (userMode_r |-> !userIoFloat_r)
    else $error("user I/O floating in user mode");
  user_ignore_a: assert property (
    (userMode_r && configRequest_n && !regWr) [*4] |=> userMode_r)
    else $error("user mode left without request");
  ts_abort_a: assert property (testPortActive |=> !activeSerialEn_r)
    else $error("active serial kept during test port");
  scheme_hold_a: assert property ($changed(scheme_r) |-> scheme_r == schemeSelect)
    else $error("scheme not taken from pins");
  restart_a: assert property ($rose(configRequest_n) |->
    ##[1:8] (!errorStatusOe && configCompleteOe && !userMode_r))
    else $error("no new configuration after request");
endmodule // cfg_handshake_checker
bind fpga_config_handshake_control cfg_handshake_checker chkU
(
  .ref_clk, .rst_n, .schemeSelect, .configRequest_n, .testPortActive, .configCompleteIn,
  .regWr, .errorStatusOe, .configCompleteOe, .userMode_r, .userIoFloat_r,
  .activeSerialEn_r, .scheme_r
);

// >>> tb/cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model
#(
  parameter [7:0] MEM_HOLD = 8'h28
)
(
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // pull-downs
  input wire devErrOe,
  input wire devDoneOe,
  input wire pullErr,
  input wire pullDone,
  // resolved lines
  output wire errLine,
  output wire doneLine
);
  // memory keeps the error line low well past the device's own hold
  reg [7:0] holdCnt_r;
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      holdCnt_r <= MEM_HOLD;
    else if (holdCnt_r != 8'h00)
      holdCnt_r <= holdCnt_r - 8'h01;
  end
  // pull-ups: any driver low wins
  assign errLine = ~(devErrOe | pullErr | (holdCnt_r != 8'h00));
  assign doneLine = ~(devDoneOe | pullDone);
endmodule // cfg_host_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg ref_clk, rst_n, configRequest_n, chainEnable_n, dataStrobe, dataError;
  reg testPortActive, activeSerialActive, regWr, regRd, pullErr, pullDone;
  reg [1:0] schemeSelect;
  reg [3:0] regAddr;
  reg [31:0] regWrData, d;
  wire [31:0] regRdData;
  wire [1:0] scheme_r;
  wire errLine, doneLine, errorStatusOe, configCompleteOe, irq, errOut_n, doneOut;
  wire userMode_r, userIoFloat_r, activeSerialEn_r;
  wire [3:0] watch = {errLine, userMode_r, configCompleteOe, errorStatusOe};
  integer num_errors, compares;
  fpga_config_handshake_control
  #(
    .POR_HOLD_CYCLES(32'h0000_000a),
    .CFG_BITS(32'h0000_0008)
  )
  dut_u
  (
    .ref_clk, .rst_n, .schemeSelect, .configRequest_n, .chainEnable_n,
    .errorStatusIn_n(errLine), .errorStatusOut_n(errOut_n), .errorStatusOe,
    .configCompleteIn(doneLine), .configCompleteOut(doneOut), .configCompleteOe,
    .dataStrobe, .dataError, .testPortActive, .activeSerialActive,
    .userMode_r, .userIoFloat_r, .activeSerialEn_r, .scheme_r,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .irq
  );
  cfg_host_model hostU
  (
    .ref_clk, .rst_n, .devErrOe(errorStatusOe), .devDoneOe(configCompleteOe),
    .pullErr, .pullDone, .errLine, .doneLine
  );
  ////////////////////////////////////////
  task final_report;
    $display("checks %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input [8*6:1] nm, input [31:0] e, input [31:0] g);
    compares = compares + 1;
    if (g !== e)
    begin
      num_errors = num_errors + 1;
      $display("ERROR %0s exp %0h got %0h", nm, e, g);
    end
  endtask
  // settle past the edge so sampling never races the design
  task cyc(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task waitSig(input [1:0] s, input v);
    integer n;
    for (n = 0; n < 300 && watch[s] !== v; n = n + 1)
      cyc(1);
    chk("wait", v, watch[s]);
    if (watch[s] !== v)
      final_report;
  endtask
  task regW(input [3:0] a, input [31:0] v);
    @(posedge ref_clk) regAddr <= a;
    regWrData <= v;
    regWr <= 1'h1;
    @(posedge ref_clk) regWr <= 1'h0;
    #1;
  endtask
  task regR(input [3:0] a);
    @(posedge ref_clk) regAddr <= a;
    regRd <= 1'h1;
    @(posedge ref_clk) regRd <= 1'h0;
    #1 d = regRdData;
  endtask
  task sendBits(input integer n);
    repeat (n)
    begin
      @(posedge ref_clk) dataStrobe <= 1'h1;
      @(posedge ref_clk) dataStrobe <= 1'h0;
    end
    #1;
  endtask
  task load;
    cyc(8);
    sendBits(7);
    chk("doneOe", 1'h1, configCompleteOe);
    sendBits(1);
    waitSig(2'h1, 1'h0);
    waitSig(2'h2, 1'h1);
  endtask
  task restart;
    @(posedge ref_clk) configRequest_n <= 1'h0;
    cyc(6);
    chk("float", 1'h1, userIoFloat_r);
    chk("user", 1'h0, userMode_r);
    @(posedge ref_clk) configRequest_n <= 1'h1;
    waitSig(2'h0, 1'h0);
  endtask
  ////////////////////////////////////////
  task t_power;
    waitSig(2'h0, 1'h0);
    chk("errLn", 1'h0, errLine);
    chk("errVal", 1'h0, errOut_n);
    chk("donVal", 1'h0, doneOut);
    waitSig(2'h3, 1'h1);
    load;
    regR(4'h4);
    chk("stat", 1'h1, d[0]);
    regW(4'h8, 32'h0000_0001);
    chk("irq", 1'h1, irq);
    regR(4'h8);
    chk("mask", 32'h0000_0001, d);
    regW(4'h4, 32'h0000_000f);
    chk("irq", 1'h0, irq);
    regR(4'h2);
    chk("unmap", 32'h0000_0000, d);
    $display("t_power done");
  endtask
  task t_ignore;
    @(posedge ref_clk) pullErr <= 1'h1;
    pullDone <= 1'h1;
    cyc(20);
    chk("user", 1'h1, userMode_r);
    @(posedge ref_clk) pullErr <= 1'h0;
    pullDone <= 1'h0;
    regW(4'hc, 32'h0000_0001);
    cyc(3);
    chk("soft", 1'h0, userMode_r);
    chk("softFl", 1'h1, userIoFloat_r);
    $display("t_ignore done");
  endtask
  task t_scheme;
    @(posedge ref_clk) schemeSelect <= 2'h1;
    restart;
    load;
    chk("scheme", 2'h1, scheme_r);
    regR(4'h0);
    chk("schReg", 2'h1, d[7:6]);
    @(posedge ref_clk) schemeSelect <= 2'h0;
    $display("t_scheme done");
  endtask
  task t_errors;
    restart;
    cyc(8);
    @(posedge ref_clk) dataError <= 1'h1;
    waitSig(2'h0, 1'h1);
    @(posedge ref_clk) dataError <= 1'h0;
    restart;
    cyc(8);
    @(posedge ref_clk) pullErr <= 1'h1;
    waitSig(2'h0, 1'h1);
    @(posedge ref_clk) pullErr <= 1'h0;
    restart;
    cyc(8);
    chk("asEn", 1'h1, activeSerialEn_r);
    @(posedge ref_clk) testPortActive <= 1'h1;
    activeSerialActive <= 1'h1;
    cyc(3);
    chk("asEn", 1'h0, activeSerialEn_r);
    regR(4'h4);
    chk("abort", 1'h1, d[2]);
    @(posedge ref_clk) testPortActive <= 1'h0;
    activeSerialActive <= 1'h0;
    restart;
    load;
    $display("t_errors done");
  endtask
  ////////////////////////////////////////
  initial
  begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    {rst_n, dataStrobe, dataError, testPortActive, activeSerialActive} = 5'h00;
    {regWr, regRd, pullErr, pullDone, regAddr, regWrData} = 40'h00_0000_0000;
    chainEnable_n = 1'h0;
    configRequest_n = 1'h1;
    schemeSelect = 2'h0;
    num_errors = 0;
    compares = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_power;
    t_ignore;
    t_scheme;
    t_errors;
    final_report;
  end
endmodule // testbench
